// file: pmta_pkg.sv
// package for the program memory table access block
// assumes a single core clock domain and the plain register port
package pmta_pkg;

  // ----------------------------------------
  // register indices on the register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_NVM_CONTROL = 4'h0;
  localparam logic [3:0] OFF_NVM_UNLOCK = 4'h1;
  localparam logic [3:0] OFF_TABLE_BYTE_LATCH = 4'h2;
  localparam logic [3:0] OFF_POINTER_LOW_BYTE = 4'h3;
  localparam logic [3:0] OFF_POINTER_HIGH_BYTE = 4'h4;
  localparam logic [3:0] OFF_POINTER_UPPER_BYTE = 4'h5;
  localparam logic [3:0] OFF_PERIPHERAL_FLAGS_TWO = 4'h6;

  // ----------------------------------------
  // nvm_control fields
  // ----------------------------------------
  localparam int CTL_SPACE_SELECT = 7;
  localparam int CTL_CONFIG_SELECT = 6;
  localparam int CTL_ROW_ERASE = 4;
  localparam int CTL_WRITE_ERROR = 3;
  localparam int CTL_WRITE_PERMIT = 2;
  localparam int CTL_WRITE_START = 1;
  localparam int CTL_READ_START = 0;
  localparam int FLAGS_MEMORY_DONE = 4;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int PTR_W = 22;
  localparam int LOW_PTR_W = 21;
  localparam int HOLD_COUNT = 32;
  localparam int HOLD_IDX_W = 5;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_W = 16;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [21:0] PTR_RESET = 22'h000000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 2000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } pmta_ptr_mode_t;

  typedef enum logic [1:0] {
    TGT_DATA_EEPROM,
    TGT_PROGRAM,
    TGT_CONFIG
  } pmta_target_t;

  typedef struct packed {
    logic valid;
    logic write;
    pmta_ptr_mode_t mode;
  } pmta_table_op_t;

  typedef struct packed {
    logic rd_en;
    logic [PTR_W-1:0] rd_addr;
    logic prog;
    logic erase;
    logic eeprom_wr;
    logic eeprom_rd;
    pmta_target_t target;
    logic [BLOCK_W-1:0] block;
  } pmta_flash_cmd_t;

endpackage

// file: pmta_table_access.sv
// program memory table access: byte latch, pointer, holding registers,
// nvm control register and the self-timed program/erase sequencing
// assumes the core waits while table_op_ready_o is low and stops fetching
// while fetch_stall_o is high; flash read data must be valid in the same cycle as rd_en
//
// Operation
// - table read moves exactly one byte
// - program writes whole 32-byte block only
// - erase 64-byte blocks, no bulk erase
// - fetch stalls until timer ends operation
// - all transfers pass the 8-bit latch
// - any byte address allowed, no alignment
// - table write fills holding register ptr[4:0]
// - unlock location reads zero, no storage
// - space select: one program, zero eeprom
// - configuration select overrides space select
// - row erase on next start, cleared after
// - write permit gates cycles, resets clear
// - error set on start, cleared on completion
// - error keeps both select bits unchanged; here the reset before a cut clears both to zero
// - write start set-only, hardware clears it
// - completion sets memory done flag bit 4
// - read start one cycle, blocked by selects
// - 22-bit pointer from three byte registers
// - keep, post-inc, post-dec or pre-inc pointer
// - steps change only low 21 pointer bits
// - table read uses all 22 pointer bits
// - block chosen by pointer bits 21:6
// - holding bytes reset to ffh, ffh keeps
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pmta_table_access
  import pmta_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // table instructions from the core
  input wire pmta_table_op_t table_op_i,
  output logic table_op_ready_o,
  output logic fetch_stall_o,
  // reset controller: previous cycle was cut by a reset
  input wire logic cycle_cut_i,
  // flash array side
  output pmta_flash_cmd_t flash_cmd_o,
  input wire logic [15:0] flash_rd_data_i,
  output logic [HOLD_COUNT*8-1:0] flash_hold_data_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ_WAIT,
    ST_PROG
  } pmta_state_t;

  typedef struct packed {
    pmta_state_t state;
    logic first;
    logic space_select;
    logic configuration_select;
    logic row_erase;
    logic write_error_flag;
    logic write_permit;
    logic write_start;
    logic read_start;
    logic memory_done_flag;
    logic unlock_half;
    logic unlock_armed;
    logic [7:0] table_byte_latch;
    logic [PTR_W-1:0] table_byte_pointer;
    logic rd_byte_sel;
    logic [HOLD_COUNT-1:0][7:0] hold;
    logic [TIMER_W-1:0] timer;
    logic cycle_erase;
    pmta_flash_cmd_t cmd;
    logic [7:0] rdata;
  } pmta_regs_t;

  pmta_regs_t r_reg;
  pmta_regs_t r_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // the top bit is never carried into, so id/config space stays put
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic down);
    logic [LOW_PTR_W-1:0] low;
    low = p[LOW_PTR_W-1:0];
    if (down) begin
      low = low - {{(LOW_PTR_W-1){1'b0}}, 1'b1};
    end else begin
      low = low + {{(LOW_PTR_W-1){1'b0}}, 1'b1};
    end
    return {p[PTR_W-1], low};
  endfunction

  function automatic pmta_target_t target_of(input logic ss, input logic cs);
    if (cs) begin
      return TGT_CONFIG;
    end else if (ss) begin
      return TGT_PROGRAM;
    end
    return TGT_DATA_EEPROM;
  endfunction

  function automatic logic [7:0] control_byte(input pmta_regs_t s);
    return {s.space_select, s.configuration_select, 1'b0, s.row_erase,
            s.write_error_flag, s.write_permit, s.write_start, s.read_start};
  endfunction

  logic wr_ctl;
  logic wr_unlock;
  logic [PTR_W-1:0] op_addr;
  logic prog_done;
  logic [TIMER_W-1:0] prog_len;

  assign wr_ctl = reg_wr_i && (reg_addr_i == OFF_NVM_CONTROL);
  assign wr_unlock = reg_wr_i && (reg_addr_i == OFF_NVM_UNLOCK);
  assign op_addr = (table_op_i.mode == PTR_PRE_INC) ? ptr_step(r_reg.table_byte_pointer, 1'b0)
                                                    : r_reg.table_byte_pointer;
  assign prog_len = TIMER_W'(PROG_CYCLES_P - 1);
  assign prog_done = (r_reg.state == ST_PROG) && (r_reg.timer == prog_len);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.cmd.rd_en = 1'b0;
    r_next.cmd.prog = 1'b0;
    r_next.cmd.erase = 1'b0;
    r_next.cmd.eeprom_wr = 1'b0;
    r_next.cmd.eeprom_rd = 1'b0;
    r_next.read_start = 1'b0;
    r_next.first = 1'b0;

    // register writes
    if (reg_wr_i && r_reg.state != ST_PROG) begin
      case (reg_addr_i)
        OFF_NVM_CONTROL: begin
          r_next.space_select = reg_wdata_i[CTL_SPACE_SELECT];
          r_next.configuration_select = reg_wdata_i[CTL_CONFIG_SELECT];
          r_next.row_erase = reg_wdata_i[CTL_ROW_ERASE];
          r_next.write_error_flag = reg_wdata_i[CTL_WRITE_ERROR];
          r_next.write_permit = reg_wdata_i[CTL_WRITE_PERMIT];
          if (reg_wdata_i[CTL_READ_START] && !reg_wdata_i[CTL_SPACE_SELECT]
              && !reg_wdata_i[CTL_CONFIG_SELECT]) begin
            r_next.read_start = 1'b1;
            r_next.cmd.eeprom_rd = 1'b1;
          end
          if (reg_wdata_i[CTL_WRITE_START]) begin
            if (reg_wdata_i[CTL_WRITE_PERMIT] && r_reg.unlock_armed) begin
              r_next.write_start = 1'b1;
              r_next.write_error_flag = 1'b1;
              r_next.state = ST_PROG;
              r_next.timer = '0;
              r_next.cmd.target = target_of(reg_wdata_i[CTL_SPACE_SELECT],
                                            reg_wdata_i[CTL_CONFIG_SELECT]);
              r_next.cmd.block = r_reg.table_byte_pointer[PTR_W-1:BLOCK_LSB];
              if (!reg_wdata_i[CTL_SPACE_SELECT] && !reg_wdata_i[CTL_CONFIG_SELECT]) begin
                r_next.cmd.eeprom_wr = 1'b1;
                r_next.cycle_erase = 1'b0;
              end else if (reg_wdata_i[CTL_ROW_ERASE]) begin
                r_next.cmd.erase = 1'b1;
                r_next.cycle_erase = 1'b1;
              end else begin
                r_next.cmd.prog = 1'b1;
                r_next.cycle_erase = 1'b0;
              end
            end else begin
              r_next.write_error_flag = 1'b1;
            end
          end
        end
        OFF_TABLE_BYTE_LATCH: begin
          r_next.table_byte_latch = reg_wdata_i;
        end
        OFF_POINTER_LOW_BYTE: begin
          r_next.table_byte_pointer[7:0] = reg_wdata_i;
        end
        OFF_POINTER_HIGH_BYTE: begin
          r_next.table_byte_pointer[15:8] = reg_wdata_i;
        end
        OFF_POINTER_UPPER_BYTE: begin
          r_next.table_byte_pointer[PTR_W-1:16] = reg_wdata_i[PTR_W-17:0];
        end
        OFF_PERIPHERAL_FLAGS_TWO: begin
          r_next.memory_done_flag = reg_wdata_i[FLAGS_MEMORY_DONE];
        end
        default: begin
        end
      endcase
    end

    // unlock sequence: 55h then aah, any other register write breaks it
    if (reg_wr_i) begin
      r_next.unlock_half = wr_unlock && (reg_wdata_i == UNLOCK_FIRST);
      r_next.unlock_armed = (wr_unlock && r_reg.unlock_half && (reg_wdata_i == UNLOCK_SECOND))
                            || (wr_unlock && r_reg.unlock_armed);
      if (wr_ctl) begin
        r_next.unlock_armed = 1'b0;
      end
    end

    // a cut cycle leaves the error showing; after the writes so the set wins
    if (r_reg.first && cycle_cut_i) begin
      r_next.write_error_flag = 1'b1;
    end

    // table instructions
    case (r_reg.state)
      ST_IDLE: begin
        if (table_op_i.valid) begin
          if (table_op_i.write) begin
            r_next.hold[op_addr[HOLD_IDX_W-1:0]] = r_reg.table_byte_latch;
          end else begin
            r_next.cmd.rd_en = 1'b1;
            r_next.cmd.rd_addr = op_addr;
            r_next.rd_byte_sel = op_addr[0];
            r_next.state = ST_READ_WAIT;
          end
          case (table_op_i.mode)
            PTR_POST_INC: r_next.table_byte_pointer = ptr_step(r_reg.table_byte_pointer, 1'b0);
            PTR_POST_DEC: r_next.table_byte_pointer = ptr_step(r_reg.table_byte_pointer, 1'b1);
            PTR_PRE_INC: r_next.table_byte_pointer = op_addr;
            default: begin
            end
          endcase
        end
      end
      ST_READ_WAIT: begin
        // one byte of the word, picked by the byte address lsb
        r_next.table_byte_latch = r_reg.rd_byte_sel ? flash_rd_data_i[15:8]
                                                    : flash_rd_data_i[7:0];
        r_next.state = ST_IDLE;
      end
      ST_PROG: begin
        r_next.timer = r_reg.timer + {{(TIMER_W-1){1'b0}}, 1'b1};
        if (prog_done) begin
          r_next.state = ST_IDLE;
          r_next.write_start = 1'b0;
          r_next.write_error_flag = 1'b0;
          r_next.memory_done_flag = 1'b1;
          if (r_reg.cycle_erase) begin
            r_next.row_erase = 1'b0;
          end else begin
            r_next.hold = {HOLD_COUNT{HOLD_RESET}};
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // register reads, data one cycle later
    r_next.rdata = BYTE_RESET;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_NVM_CONTROL: r_next.rdata = control_byte(r_reg);
        OFF_NVM_UNLOCK: r_next.rdata = BYTE_RESET;
        OFF_TABLE_BYTE_LATCH: r_next.rdata = r_reg.table_byte_latch;
        OFF_POINTER_LOW_BYTE: r_next.rdata = r_reg.table_byte_pointer[7:0];
        OFF_POINTER_HIGH_BYTE: r_next.rdata = r_reg.table_byte_pointer[15:8];
        OFF_POINTER_UPPER_BYTE: r_next.rdata = {2'b00, r_reg.table_byte_pointer[PTR_W-1:16]};
        OFF_PERIPHERAL_FLAGS_TWO: r_next.rdata = {3'b000, r_reg.memory_done_flag, 4'h0};
        default: r_next.rdata = BYTE_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.first <= 1'b1;
      r_reg.table_byte_pointer <= PTR_RESET;
      r_reg.hold <= {HOLD_COUNT{HOLD_RESET}};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_o = r_reg.rdata;
  assign table_op_ready_o = (r_reg.state == ST_IDLE);
  assign fetch_stall_o = (r_reg.state == ST_PROG);
  assign flash_cmd_o = r_reg.cmd;
  assign flash_hold_data_o = r_reg.hold;

endmodule

`default_nettype wire

// file: pmta_checker.sv
// checker for the program memory table access block
// sees only the top ports; bound by the statement at the foot
`timescale 1ns/1ps
`default_nettype none

module pmta_checker
  import pmta_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // core and flash side
  input wire pmta_table_op_t table_op_i,
  input wire logic table_op_ready_o,
  input wire logic fetch_stall_o,
  input wire pmta_flash_cmd_t flash_cmd_o,
  input wire logic [HOLD_COUNT*8-1:0] flash_hold_data_o
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [15:0] stall_cnt_reg;
  logic prog_seen_reg;
  logic ctl_wr;
  assign ctl_wr = reg_wr_i && reg_addr_i == OFF_NVM_CONTROL && !fetch_stall_o;
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // counter, since the timer length is a parameter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_cnt_reg <= 16'h0000;
      prog_seen_reg <= 1'b0;
    end else begin
      stall_cnt_reg <= fetch_stall_o ? stall_cnt_reg + 16'h0001 : 16'h0000;
      prog_seen_reg <= flash_cmd_o.prog || (prog_seen_reg && fetch_stall_o);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_UNLOCK_READS_ZERO: assert property (reg_rd_i && reg_addr_i == OFF_NVM_UNLOCK |=> reg_rdata_o == 8'h00)
    else $error("unlock location read not zero");
  AST_BIT5_ZERO: assert property (reg_rd_i && reg_addr_i == OFF_NVM_CONTROL |=> !reg_rdata_o[5])
    else $error("control bit 5 read as one");
  AST_ONE_FETCH: assert property (table_op_i.valid && table_op_ready_o && !table_op_i.write
    |=> flash_cmd_o.rd_en && !table_op_ready_o ##1 !flash_cmd_o.rd_en && table_op_ready_o)
    else $error("table read fetch not single");
  AST_STALL_LEN: assert property ($fell(fetch_stall_o) |-> stall_cnt_reg == PROG_CYCLES_P)
    else $error("stall length differs from timer");
  AST_START_STALLS: assert property (flash_cmd_o.prog || flash_cmd_o.erase |-> $rose(fetch_stall_o))
    else $error("timed cycle without fetch stall");
  AST_HOLD_REFILL: assert property ($fell(fetch_stall_o) && prog_seen_reg
    |-> ##[0:1] flash_hold_data_o == {HOLD_COUNT{HOLD_RESET}})
    else $error("holding bytes not refilled");
  AST_NO_PERMIT: assert property (ctl_wr && reg_wdata_i[1] && !reg_wdata_i[2]
    |=> !fetch_stall_o ##1 !fetch_stall_o)
    else $error("cycle began without permit");
  AST_READ_BLOCKED: assert property (ctl_wr && reg_wdata_i[0] && reg_wdata_i[7:6] != 2'b00
    |=> !flash_cmd_o.eeprom_rd ##1 !flash_cmd_o.eeprom_rd)
    else $error("eeprom read with select set");
endmodule

bind pmta_table_access pmta_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_pmta_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .table_op_i(table_op_i),
  .table_op_ready_o(table_op_ready_o), .fetch_stall_o(fetch_stall_o), .flash_cmd_o(flash_cmd_o),
  .flash_hold_data_o(flash_hold_data_o));
`default_nettype wire

// file: pmta_flash_model.sv
// flash array model: a word during each read pulse
// assumes the table access block's command struct
`timescale 1ns/1ps
`default_nettype none

module pmta_flash_model
  import pmta_pkg::*;
(
  // core clock and command
  input wire logic sys_clk_i,
  input wire pmta_flash_cmd_t flash_cmd_i,
  // read word
  output logic [15:0] flash_rd_data_o
);
  logic [20:0] w;
  logic [15:0] junk_reg = 16'h0000;
  assign w = flash_cmd_i.rd_addr[21:1];
  // outside a read the bus toggles, so stale data never matches
  always_ff @(posedge sys_clk_i) begin
    junk_reg <= ~junk_reg;
  end
  // the block latches the word at the edge that ends its read pulse
  assign flash_rd_data_o = flash_cmd_i.rd_en ? {w[15:8] ^ 8'h5a, w[7:0] ^ {w[20], 7'h00}} : junk_reg;
endmodule
`default_nettype wire

// file: pmta_table_access_test.sv
// testbench for the program memory table access block
// assumes the checker bind and the flash model beside it
`timescale 1ns/1ps
`default_nettype none

module pmta_table_access_test import pmta_pkg::*;;
  localparam int P = 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cut = 1'b0;
  logic [7:0] rdata;
  logic ready;
  logic stall;
  logic [15:0] frd;
  logic [255:0] hold;
  pmta_table_op_t op = '0;
  pmta_flash_cmd_t cmd;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  pmta_table_access #(.PROG_CYCLES_P(P)) u_pmta_table_access (.sys_clk_i(sys_clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .table_op_i(op), .table_op_ready_o(ready), .fetch_stall_o(stall), .cycle_cut_i(cut),
    .flash_cmd_o(cmd), .flash_rd_data_i(frd), .flash_hold_data_o(hold));
  pmta_flash_model u_pmta_flash_model (.sys_clk_i(sys_clk), .flash_cmd_i(cmd), .flash_rd_data_o(frd));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic tbl_op(input logic w, input pmta_ptr_mode_t m);
    @(posedge sys_clk);
    op <= '{valid: 1'b1, write: w, mode: m};
    @(posedge sys_clk);
    op.valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // expected byte, worked out from the model's word pattern
  function automatic logic [7:0] ex(input logic [21:0] a);
    logic [20:0] w;
    w = a[21:1];
    return a[0] ? w[15:8] ^ 8'h5a : w[7:0] ^ {w[20], 7'h00};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[3:0], 8'h00);
    end
    chk(hold[31:0], 32'hffffffff);
  endtask
  task automatic t_table_read();
    wr_reg(OFF_POINTER_LOW_BYTE, 8'hff);
    wr_reg(OFF_POINTER_HIGH_BYTE, 8'hff);
    wr_reg(OFF_POINTER_UPPER_BYTE, 8'h3f);
    tbl_op(1'b0, PTR_POST_INC);
    rd_reg(OFF_TABLE_BYTE_LATCH, ex(22'h3fffff));
    tbl_op(1'b0, PTR_KEEP);
    rd_reg(OFF_TABLE_BYTE_LATCH, ex(22'h200000));
    tbl_op(1'b0, PTR_POST_DEC);
    rd_reg(OFF_TABLE_BYTE_LATCH, ex(22'h200000));
    tbl_op(1'b0, PTR_PRE_INC);
    rd_reg(OFF_TABLE_BYTE_LATCH, ex(22'h200000));
    rd_reg(OFF_POINTER_UPPER_BYTE, 8'h20);
  endtask
  task automatic t_table_write();
    wr_reg(OFF_TABLE_BYTE_LATCH, 8'h3c);
    wr_reg(OFF_POINTER_LOW_BYTE, 8'h47);
    tbl_op(1'b1, PTR_POST_INC);
    chk(hold[63:56], 8'h3c);
    chk(hold[71:64], 8'hff);
    rd_reg(OFF_POINTER_LOW_BYTE, 8'h48);
  endtask
  task automatic t_timed();
    logic [7:0] ctl [4] = '{8'h96, 8'h86, 8'hc6, 8'h06};
    logic [2:0] pul [4] = '{3'b010, 3'b100, 3'b100, 3'b001};
    pmta_target_t tgt [4] = '{TGT_PROGRAM, TGT_PROGRAM, TGT_CONFIG, TGT_DATA_EEPROM};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFF_NVM_UNLOCK, UNLOCK_FIRST);
      wr_reg(OFF_NVM_UNLOCK, UNLOCK_SECOND);
      wr_reg(OFF_NVM_CONTROL, ctl[i]);
      #1 chk({cmd.prog, cmd.erase, cmd.eeprom_wr}, pul[i]);
      chk(cmd.target, tgt[i]);
      chk(cmd.block, 16'h8001);
      n = 0;
      while (stall === 1'b1 && n < 100) begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk(n, P);
      rd_reg(OFF_NVM_CONTROL, ctl[i] & 8'hc4);
      rd_reg(OFF_PERIPHERAL_FLAGS_TWO, 8'h10);
      wr_reg(OFF_PERIPHERAL_FLAGS_TWO, 8'h00);
      chk(hold[63:56], i == 0 ? 8'h3c : 8'hff);
    end
  endtask
  task automatic t_refused();
    logic seen;
    wr_reg(OFF_NVM_CONTROL, 8'h82);
    #1 chk(stall, 1'b0);
    rd_reg(OFF_NVM_CONTROL, 8'h88);
    wr_reg(OFF_NVM_CONTROL, 8'ha6);
    #1 chk(stall, 1'b0);
    rd_reg(OFF_NVM_CONTROL, 8'h8c);
    wr_reg(OFF_NVM_CONTROL, 8'h81);
    rd_reg(OFF_NVM_CONTROL, 8'h80);
    wr_reg(OFF_NVM_CONTROL, 8'h01);
    seen = 1'b0;
    repeat (2) begin
      #1 seen = seen | cmd.eeprom_rd;
      @(posedge sys_clk);
    end
    chk(seen, 1'b1);
    rd_reg(OFF_NVM_CONTROL, 8'h00);
  endtask
  task automatic t_cut();
    @(posedge sys_clk);
    rst <= 1'b1;
    cut <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cut <= 1'b0;
    rd_reg(OFF_NVM_CONTROL, 8'h08);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_values();
    t_table_read();
    t_table_write();
    t_timed();
    t_refused();
    t_cut();
    report_and_stop();
  end
endmodule
`default_nettype wire
